/* File: rtl/trap_and_interrupt_flag_control.v */
// Purpose: Trap status, trap enables, vector table select, external
//          edge polarity and two banks of sticky interrupt request flags.
// Assumes: Core and peripheral event inputs are one-cycle pulses on MCLK;
//          external interrupt pins are asynchronous.
// Notes:   Hardware sets win over software clears in the same cycle.
`timescale 1ns/1ns
`include "trap_flag_ctrl_regs.vh"

// Functional notes
// - Nesting-disable set forbids nested interrupts; clear permits them.
// - Accumulator A overflow trap sets its overflow flag.
// - Accumulator B overflow trap sets its overflow flag.
// - Accumulator A catastrophic overflow trap sets its flag.
// - Accumulator B catastrophic overflow trap sets its flag.
// - Accumulator A overflow traps only while its enable is set.
// - Accumulator B overflow traps only while its enable is set.
// - One enable gates catastrophic overflow traps of both accumulators.
// - Invalid accumulator shift math trap sets the bad-shift status.
// - Divide-by-zero math trap sets the divide-zero status.
// - Any math error trap sets the general math status.
// - Address error trap sets the address trap status.
// - Stack error trap sets the stack trap status.
// - Oscillator failure trap sets the oscillator failure status.
// - Vector select set picks alternate table, clear picks default.
// - Read-only bit shows interrupt-disable instruction active; resets 0.
// - Three polarity bits pick falling (1) or rising (0) edge.
// - Bank zero holds peripheral request flags at bits 13 to 5.
// - Bank zero holds timer 1, compare 1, capture 1, ext 0 flags.
// - Bank one holds ext 2, ext 1, change, comparator, two-wire flags.
// - Unimplemented bits read zero and ignore writes.
module trap_and_interrupt_flag_control (
   input wire MCLK,
   input wire RST_N,
   input wire [2:0] ADDR,
   input wire [15:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [15:0] RDATA,
   input wire ACC_A_OVF,
   input wire ACC_B_OVF,
   input wire ACC_A_COVF,
   input wire ACC_B_COVF,
   input wire BAD_SHIFT,
   input wire DIV_ZERO,
   input wire ADDR_ERR,
   input wire STACK_ERR,
   input wire OSC_FAIL,
   input wire IRQ_DISABLE_INSTR_ACTIVE_ACTIVE,
   input wire ISR_ENTER,
   input wire ISR_RETURN,
   input wire [15:0] BANK0_EVT,
   input wire [15:0] BANK1_EVT,
   input wire [2:0] EXT_IRQ,
   output reg TRAP_PULSE,
   output reg MATH_TRAP_PULSE,
   output wire ALT_VECTOR,
   output wire NEST_BLOCK,
   output wire [15:0] REQ_FLAGS0,
   output wire [15:0] REQ_FLAGS1
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   reg [15:0] trap_status_control_reg;
   reg [15:0] trap_status_control_next;
   reg [15:0] vector_edge_reg;
   reg [15:0] vector_edge_next;
   reg [15:0] flags_bank_zero_reg;
   reg [15:0] flags_bank_zero_next;
   reg [15:0] flags_bank_one_reg;
   reg [15:0] flags_bank_one_next;
   reg irq_disable_instr_active_reg;
   reg [2:0] ext_meta_reg;
   reg [2:0] ext_sync_reg;
   reg [2:0] ext_prev_reg;
   reg [`DEPTH_WIDTH-1:0] depth_reg;
   reg [`DEPTH_WIDTH-1:0] depth_next;
   reg [15:0] rdata_next;
   reg [15:0] trap_set;
   reg [15:0] bank0_set;
   reg [15:0] bank1_set;
   wire nesting_disable;
   wire acc_a_overflow_trap_en;
   wire acc_b_overflow_trap_en;
   wire catastrophic_trap_en;
   wire acc_a_trap;
   wire acc_b_trap;
   wire acc_a_cat_trap;
   wire acc_b_cat_trap;
   wire math_trap;
   wire any_trap;
   wire [2:0] ext_polarity;
   wire [2:0] ext_rise;
   wire [2:0] ext_fall;
   wire [2:0] ext_edge;
   wire wr_trap;
   wire wr_vector;
   wire wr_bank0;
   wire wr_bank1;

   ////////////////////////////////////////////////////////////////////////
   // Control field views
   assign nesting_disable =
      trap_status_control_reg[`BIT_NESTING_DISABLE];
   assign acc_a_overflow_trap_en =
      trap_status_control_reg[`BIT_ACC_A_OVERFLOW_TRAP_EN];
   assign acc_b_overflow_trap_en =
      trap_status_control_reg[`BIT_ACC_B_OVERFLOW_TRAP_EN];
   assign catastrophic_trap_en =
      trap_status_control_reg[`BIT_CATASTROPHIC_TRAP_EN];
   assign ext_polarity = {vector_edge_reg[`BIT_EXT_IRQ_TWO_POLARITY],
                          vector_edge_reg[`BIT_EXT_IRQ_ONE_POLARITY],
                          vector_edge_reg[`BIT_EXT_IRQ_ZERO_POLARITY]};

   // Vector table choice goes straight to the fetch logic
   assign ALT_VECTOR = vector_edge_reg[`BIT_ALT_VECTOR_SELECT];

   ////////////////////////////////////////////////////////////////////////
   // Trap qualification; an overflow with its enable clear is not a trap
   assign acc_a_trap = ACC_A_OVF & acc_a_overflow_trap_en;
   assign acc_b_trap = ACC_B_OVF & acc_b_overflow_trap_en;
   assign acc_a_cat_trap = ACC_A_COVF & catastrophic_trap_en;
   assign acc_b_cat_trap = ACC_B_COVF & catastrophic_trap_en;

   // Every accumulator, shift or divide trap is a math error trap
   assign math_trap = acc_a_trap | acc_b_trap | acc_a_cat_trap |
                      acc_b_cat_trap | BAD_SHIFT | DIV_ZERO;
   assign any_trap = math_trap | ADDR_ERR | STACK_ERR | OSC_FAIL;

   ////////////////////////////////////////////////////////////////////////
   // Write decode
   assign wr_trap = WR & (ADDR == `OFS_TRAP_STATUS_CONTROL);
   assign wr_vector = WR & (ADDR == `OFS_VECTOR_EDGE_CONTROL);
   assign wr_bank0 = WR & (ADDR == `OFS_REQ_FLAGS_BANK_ZERO);
   assign wr_bank1 = WR & (ADDR == `OFS_REQ_FLAGS_BANK_ONE);

   ////////////////////////////////////////////////////////////////////////
   // External interrupt pins: two-stage sync, then polarity edge detect.
   // Only the second stage and its delayed copy feed the detector.
   assign ext_rise = ext_sync_reg & ~ext_prev_reg;
   assign ext_fall = ~ext_sync_reg & ext_prev_reg;
   assign ext_edge = (ext_polarity & ext_fall) |
                     (~ext_polarity & ext_rise);

   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         ext_meta_reg <= 3'h0;
         ext_sync_reg <= 3'h0;
         ext_prev_reg <= 3'h0;
      end else begin
         ext_meta_reg <= EXT_IRQ;
         ext_sync_reg <= ext_meta_reg;
         ext_prev_reg <= ext_sync_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Hardware set vectors for the trap register
   always @* begin
      trap_set = 16'h0000;
      trap_set[`BIT_ACC_A_OVERFLOW_FLAG] = acc_a_trap;
      trap_set[`BIT_ACC_B_OVERFLOW_FLAG] = acc_b_trap;
      trap_set[`BIT_ACC_A_CATASTROPHIC_FLAG] = acc_a_cat_trap;
      trap_set[`BIT_ACC_B_CATASTROPHIC_FLAG] = acc_b_cat_trap;
      trap_set[`BIT_BAD_SHIFT_STATUS] = BAD_SHIFT;
      trap_set[`BIT_DIVIDE_ZERO_STATUS] = DIV_ZERO;
      trap_set[`BIT_MATH_TRAP_STATUS] = math_trap;
      trap_set[`BIT_ADDRESS_TRAP_STATUS] = ADDR_ERR;
      trap_set[`BIT_STACK_TRAP_STATUS] = STACK_ERR;
      trap_set[`BIT_OSC_FAILURE_STATUS] = OSC_FAIL;
   end

   // Peripheral and pin set vectors for the two flag banks
   always @* begin
      bank0_set = BANK0_EVT & `MASK_REQ_FLAGS_BANK_ZERO;
      bank0_set[`BIT_EXT_IRQ_ZERO_FLAG] =
         BANK0_EVT[`BIT_EXT_IRQ_ZERO_FLAG] | ext_edge[0];
      bank1_set = BANK1_EVT & `MASK_REQ_FLAGS_BANK_ONE;
      bank1_set[`BIT_EXT_IRQ_ONE_FLAG] =
         BANK1_EVT[`BIT_EXT_IRQ_ONE_FLAG] | ext_edge[1];
      bank1_set[`BIT_EXT_IRQ_TWO_FLAG] =
         BANK1_EVT[`BIT_EXT_IRQ_TWO_FLAG] | ext_edge[2];
   end

   ////////////////////////////////////////////////////////////////////////
   // Next values: software write replaces, then hardware sets are ORed
   // on top so an event in the clearing cycle is never lost.
   always @* begin
      trap_status_control_next = trap_status_control_reg;
      if (wr_trap) begin
         trap_status_control_next =
            WDATA & `MASK_TRAP_STATUS_CONTROL;
      end
      trap_status_control_next =
         trap_status_control_next | trap_set;
   end

   // Only select and polarity bits take writes; status bit is not stored
   always @* begin
      vector_edge_next = vector_edge_reg;
      if (wr_vector) begin
         vector_edge_next = WDATA & `MASK_VECTOR_EDGE_WRITE;
      end
   end

   // Request flag banks keep to the same set-wins discipline
   always @* begin
      flags_bank_zero_next = flags_bank_zero_reg;
      if (wr_bank0) begin
         flags_bank_zero_next = WDATA & `MASK_REQ_FLAGS_BANK_ZERO;
      end
      flags_bank_zero_next = flags_bank_zero_next | bank0_set;
   end

   always @* begin
      flags_bank_one_next = flags_bank_one_reg;
      if (wr_bank1) begin
         flags_bank_one_next = WDATA & `MASK_REQ_FLAGS_BANK_ONE;
      end
      flags_bank_one_next = flags_bank_one_next | bank1_set;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register state
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         trap_status_control_reg <= `RST_TRAP_STATUS_CONTROL;
         vector_edge_reg <= `RST_VECTOR_EDGE_CONTROL;
         flags_bank_zero_reg <= `RST_REQ_FLAGS_BANK_ZERO;
         flags_bank_one_reg <= `RST_REQ_FLAGS_BANK_ONE;
      end else begin
         trap_status_control_reg <= trap_status_control_next;
         vector_edge_reg <= vector_edge_next;
         flags_bank_zero_reg <= flags_bank_zero_next;
         flags_bank_one_reg <= flags_bank_one_next;
      end
   end

   // Disable-instruction status sampled from the core, zero after reset
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_disable_instr_active_reg <= 1'b0;
      end else begin
         irq_disable_instr_active_reg <= IRQ_DISABLE_INSTR_ACTIVE_ACTIVE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Trap pulses to the core, one cycle after the cause
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         TRAP_PULSE <= 1'b0;
         MATH_TRAP_PULSE <= 1'b0;
      end else begin
         TRAP_PULSE <= any_trap;
         MATH_TRAP_PULSE <= math_trap;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Service nesting depth. Saturates both ways so a stray return or a
   // runaway entry cannot wrap the count and unblock preemption.
   always @* begin
      depth_next = depth_reg;
      if (ISR_ENTER && !ISR_RETURN && depth_reg != `DEPTH_MAX) begin
         depth_next = depth_reg + 4'h1;
      end else if (ISR_RETURN && !ISR_ENTER &&
                   depth_reg != {`DEPTH_WIDTH{1'b0}}) begin
         depth_next = depth_reg - 4'h1;
      end
   end

   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         depth_reg <= {`DEPTH_WIDTH{1'b0}};
      end else begin
         depth_reg <= depth_next;
      end
   end

   // Preemption blocked while a routine runs and nesting is off
   assign NEST_BLOCK = nesting_disable &
                       (depth_reg != {`DEPTH_WIDTH{1'b0}});

   ////////////////////////////////////////////////////////////////////////
   // Flag banks go to the arbiter straight from the flops
   assign REQ_FLAGS0 = flags_bank_zero_reg;
   assign REQ_FLAGS1 = flags_bank_one_reg;

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped indices and reserved bits read zero
   always @* begin
      rdata_next = 16'h0000;
      if (ADDR == `OFS_TRAP_STATUS_CONTROL) begin
         rdata_next = trap_status_control_reg;
      end else if (ADDR == `OFS_VECTOR_EDGE_CONTROL) begin
         rdata_next = vector_edge_reg;
         rdata_next[`BIT_IRQ_DISABLE_INSTR_ACTIVE] = irq_disable_instr_active_reg;
      end else if (ADDR == `OFS_REQ_FLAGS_BANK_ZERO) begin
         rdata_next = flags_bank_zero_reg;
      end else if (ADDR == `OFS_REQ_FLAGS_BANK_ONE) begin
         rdata_next = flags_bank_one_reg;
      end
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= 16'h0000;
      end else if (RD) begin
         RDATA <= rdata_next;
      end else begin
         RDATA <= 16'h0000;
      end
   end

endmodule // trap_and_interrupt_flag_control

/* File: rtl/trap_flag_ctrl_regs.vh */
// Purpose: Offsets, field positions, masks and reset values of the
//          trap and interrupt flag control block.
// Assumes: Register index port of 3 bits, 16-bit register data.
// Notes:   Definitions only.
`ifndef TRAP_FLAG_CTRL_REGS_VH
`define TRAP_FLAG_CTRL_REGS_VH

// Register indices
`define OFS_TRAP_STATUS_CONTROL 3'h0
`define OFS_VECTOR_EDGE_CONTROL 3'h1
`define OFS_REQ_FLAGS_BANK_ZERO 3'h2
`define OFS_REQ_FLAGS_BANK_ONE 3'h3

// Trap status and control fields
`define BIT_NESTING_DISABLE 15
`define BIT_ACC_A_OVERFLOW_FLAG 14
`define BIT_ACC_B_OVERFLOW_FLAG 13
`define BIT_ACC_A_CATASTROPHIC_FLAG 12
`define BIT_ACC_B_CATASTROPHIC_FLAG 11
`define BIT_ACC_A_OVERFLOW_TRAP_EN 10
`define BIT_ACC_B_OVERFLOW_TRAP_EN 9
`define BIT_CATASTROPHIC_TRAP_EN 8
`define BIT_BAD_SHIFT_STATUS 7
`define BIT_DIVIDE_ZERO_STATUS 6
`define BIT_MATH_TRAP_STATUS 4
`define BIT_ADDRESS_TRAP_STATUS 3
`define BIT_STACK_TRAP_STATUS 2
`define BIT_OSC_FAILURE_STATUS 1

// Vector and edge control fields
`define BIT_ALT_VECTOR_SELECT 15
`define BIT_IRQ_DISABLE_INSTR_ACTIVE 14
`define BIT_EXT_IRQ_TWO_POLARITY 2
`define BIT_EXT_IRQ_ONE_POLARITY 1
`define BIT_EXT_IRQ_ZERO_POLARITY 0

// Bank zero request flag positions
`define BIT_ADC_GROUP_DONE_FLAG 13
`define BIT_SERIAL_TX_FLAG 12
`define BIT_SERIAL_RX_FLAG 11
`define BIT_SERIAL_PERIPH_EVENT_FLAG 10
`define BIT_SERIAL_PERIPH_FAULT_FLAG 9
`define BIT_TIMER_THREE_FLAG 8
`define BIT_TIMER_TWO_FLAG 7
`define BIT_COMPARE_TWO_FLAG 6
`define BIT_CAPTURE_TWO_FLAG 5
`define BIT_TIMER_ONE_FLAG 3
`define BIT_COMPARE_ONE_FLAG 2
`define BIT_CAPTURE_ONE_FLAG 1
`define BIT_EXT_IRQ_ZERO_FLAG 0

// Bank one request flag positions
`define BIT_EXT_IRQ_TWO_FLAG 13
`define BIT_EXT_IRQ_ONE_FLAG 4
`define BIT_PIN_CHANGE_FLAG 3
`define BIT_COMPARATOR_ONE_FLAG 2
`define BIT_TWO_WIRE_MASTER_FLAG 1
`define BIT_TWO_WIRE_SLAVE_FLAG 0

// Implemented-bit masks; every other bit reads zero, except read-only status bit 14 of the vector register
`define MASK_TRAP_STATUS_CONTROL 16'hFFDE
`define MASK_VECTOR_EDGE_WRITE 16'h8007
`define MASK_REQ_FLAGS_BANK_ZERO 16'h3FEF
`define MASK_REQ_FLAGS_BANK_ONE 16'h201F

// Reset values
`define RST_TRAP_STATUS_CONTROL 16'h0000
`define RST_VECTOR_EDGE_CONTROL 16'h0000
`define RST_REQ_FLAGS_BANK_ZERO 16'h0000
`define RST_REQ_FLAGS_BANK_ONE 16'h0000

// Service nesting depth counter
`define DEPTH_WIDTH 4
`define DEPTH_MAX 4'hF

`endif

/* File: testbench/core_event_model.sv */
// Purpose: Core and peripheral event sources around the flag block.
// Assumes: Bench raises fire for one cycle with kind and bits stable.
// Notes:   Kinds 0-8 traps, 9 entry, 10 return, 11 and 12 flag banks.
`timescale 1ns/1ns
module core_event_model (
   input wire fire,
   input wire [3:0] kind,
   input wire [15:0] bits,
   output wire [10:0] pulse,
   output wire [15:0] bank0,
   output wire [15:0] bank1
);
   // One-hot pulse; lines sit low between events, as real sources do
   wire [12:0] hot = fire ? (13'h0001 << kind) : 13'h0000;
   assign pulse = hot[10:0];
   assign bank0 = hot[11] ? bits : 16'h0000;
   assign bank1 = hot[12] ? bits : 16'h0000;
endmodule // core_event_model

/* File: testbench/trap_and_interrupt_flag_control_bench.sv */
// Purpose: Self-checking bench of the trap and request flag block.
// Assumes: Bus strobes one cycle, events from the core model.
// Notes:   Samples 1 ns after edges so updates have landed.
`timescale 1ns/1ns
`include "trap_flag_ctrl_regs.vh"
module trap_and_interrupt_flag_control_bench;
   logic MCLK = 1'b0;
   logic RST_N = 1'b0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic fire = 1'b0;
   logic irq_disable_instr_active = 1'b0;
   logic [2:0] ADDR = 3'h0;
   logic [2:0] ext = 3'h0;
   logic [3:0] kind = 4'h0;
   logic [15:0] WDATA = 16'h0000;
   logic [15:0] bits = 16'h0000;
   wire [15:0] RDATA, REQ_FLAGS0, REQ_FLAGS1, bank0, bank1;
   wire [10:0] pulse;
   wire ALT_VECTOR, NEST_BLOCK;
   int failures = 0;
   int checks = 0;
   logic [15:0] msk [0:3] = '{`MASK_TRAP_STATUS_CONTROL,
      `MASK_VECTOR_EDGE_WRITE, `MASK_REQ_FLAGS_BANK_ZERO,
      `MASK_REQ_FLAGS_BANK_ONE};
   logic [15:0] texp [0:8] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810,
      16'h0090, 16'h0050, 16'h0008, 16'h0004, 16'h0002};
   always #4 MCLK = ~MCLK;
   core_event_model partner (.fire(fire), .kind(kind), .bits(bits),
      .pulse(pulse), .bank0(bank0), .bank1(bank1));
   trap_and_interrupt_flag_control dut (.MCLK(MCLK), .RST_N(RST_N),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .ACC_A_OVF(pulse[0]), .ACC_B_OVF(pulse[1]), .ACC_A_COVF(pulse[2]),
      .ACC_B_COVF(pulse[3]), .BAD_SHIFT(pulse[4]), .DIV_ZERO(pulse[5]),
      .ADDR_ERR(pulse[6]), .STACK_ERR(pulse[7]), .OSC_FAIL(pulse[8]),
      .IRQ_DISABLE_INSTR_ACTIVE_ACTIVE(irq_disable_instr_active), .ISR_ENTER(pulse[9]), .ISR_RETURN(pulse[10]),
      .BANK0_EVT(bank0), .BANK1_EVT(bank1), .EXT_IRQ(ext),
      .TRAP_PULSE(), .MATH_TRAP_PULSE(), .ALT_VECTOR(ALT_VECTOR),
      .NEST_BLOCK(NEST_BLOCK), .REQ_FLAGS0(REQ_FLAGS0),
      .REQ_FLAGS1(REQ_FLAGS1));
   //////////////////////////////////////////////////////////////////////////
   // Shared compare, bus and event tasks
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task stop_test;
      if (failures == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge MCLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge MCLK);
      WR <= 1'b0;
      #1;
   endtask
   task rd(input logic [2:0] a, input logic [15:0] e,
      input logic [15:0] m = 16'hFFFF);
      @(posedge MCLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge MCLK);
      RD <= 1'b0;
      #1;
      chk(RDATA & m, e);
   endtask
   task ev(input logic [3:0] k, input logic [15:0] b);
      @(posedge MCLK);
      fire <= 1'b1;
      kind <= k;
      bits <= b;
      @(posedge MCLK);
      fire <= 1'b0;
      #1;
   endtask
   //////////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_access;
      for (int i = 0; i < 4; i++)
         rd(i, 16'h0000);
      // Unmapped indices must hold nothing
      for (int i = 0; i < 8; i++) begin
         wr(i, 16'hFFFF);
         rd(i, i < 4 ? msk[i] : 16'h0000);
         wr(i, 16'h0000);
      end
   endtask
   task t_traps;
      wr(0, 16'h0700);
      for (int k = 0; k < 4; k++) begin
         ev(k, 16'h0000);
         rd(0, 16'h0700 | texp[k]);
         wr(0, 16'h0700);
      end
      // Shift, divide and plain error traps, run with the overflow enables still set
      for (int k = 4; k < 9; k++) begin
         ev(k, 16'h0000);
         rd(0, 16'h0700 | texp[k]);
         wr(0, 16'h0700);
      end
      // Overflow with every enable clear is ignored
      wr(0, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         ev(k, 16'h0000);
         rd(0, 16'h0000);
      end
   endtask
   task t_vector;
      @(posedge MCLK);
      irq_disable_instr_active <= 1'b1;
      // Read strobe right behind the write must see the new value
      WR <= 1'b1;
      ADDR <= 3'h1;
      WDATA <= 16'hC005;
      @(posedge MCLK);
      WR <= 1'b0;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, 16'hC005);
      chk({15'h0000, ALT_VECTOR}, 16'h0001);
      @(posedge MCLK);
      irq_disable_instr_active <= 1'b0;
      wr(1, 16'h0000);
      rd(1, 16'h0000);
      chk({15'h0000, ALT_VECTOR}, 16'h0000);
   endtask
   task t_ext;
      int n;
      @(posedge MCLK);
      ext <= 3'b101;
      wr(1, 16'h0005);
      repeat (4) @(posedge MCLK);
      wr(2, 16'h0000);
      wr(3, 16'h0000);
      // Falling on pins 2 and 0, rising on pin 1
      @(posedge MCLK);
      ext <= 3'b010;
      for (n = 0; n < 10 && REQ_FLAGS1 !== 16'h2010; n++) begin
         @(posedge MCLK);
         #1;
      end
      if (n == 10) begin
         failures++;
         stop_test;
      end
      chk(REQ_FLAGS0, 16'h0001);
      wr(2, 16'h0000);
      wr(3, 16'h0000);
      // Opposite edges must not raise requests
      @(posedge MCLK);
      ext <= 3'b101;
      repeat (6) @(posedge MCLK);
      #1;
      chk(REQ_FLAGS0 | REQ_FLAGS1, 16'h0000);
      wr(1, 16'h0000);
   endtask
   task t_flags;
      ev(11, 16'hFFFF);
      rd(2, `MASK_REQ_FLAGS_BANK_ZERO);
      ev(12, 16'hFFFF);
      rd(3, `MASK_REQ_FLAGS_BANK_ONE);
      wr(3, 16'h0001);
      chk(REQ_FLAGS1, 16'h0001);
      // Event and software clear in one cycle
      @(posedge MCLK);
      WR <= 1'b1;
      ADDR <= 3'h2;
      WDATA <= 16'h0000;
      fire <= 1'b1;
      kind <= 4'hB;
      bits <= 16'h2000;
      @(posedge MCLK);
      WR <= 1'b0;
      fire <= 1'b0;
      #1;
      chk(REQ_FLAGS0, 16'h2000);
   endtask
   task t_nest;
      wr(0, 16'h8000);
      ev(9, 16'h0000);
      chk({15'h0000, NEST_BLOCK}, 16'h0001);
      ev(9, 16'h0000);
      ev(10, 16'h0000);
      chk({15'h0000, NEST_BLOCK}, 16'h0001);
      // Nesting enabled inside a running routine opens preemption
      wr(0, 16'h0000);
      chk({15'h0000, NEST_BLOCK}, 16'h0000);
      wr(0, 16'h8000);
      ev(10, 16'h0000);
      chk({15'h0000, NEST_BLOCK}, 16'h0000);
      wr(0, 16'h0000);
   endtask
   // Reset for 20 cycles, then each scenario in turn
   initial begin
      repeat (20) @(posedge MCLK);
      RST_N <= 1'b1;
      t_access;
      t_traps;
      t_vector;
      t_ext;
      t_flags;
      t_nest;
      stop_test;
   end
endmodule // trap_and_interrupt_flag_control_bench

/* File: testbench/trap_flag_checker.sv */
// Purpose: Port-level checks of the trap and request flag block.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ns
`include "trap_flag_ctrl_regs.vh"
module trap_flag_checker (
   input wire MCLK,
   input wire RST_N,
   input wire [2:0] ADDR,
   input wire [15:0] WDATA,
   input wire WR,
   input wire RD,
   input wire [15:0] RDATA,
   input wire ACC_A_OVF,
   input wire ACC_B_OVF,
   input wire ACC_A_COVF,
   input wire ACC_B_COVF,
   input wire BAD_SHIFT,
   input wire DIV_ZERO,
   input wire ADDR_ERR,
   input wire STACK_ERR,
   input wire OSC_FAIL,
   input wire [15:0] BANK0_EVT,
   input wire TRAP_PULSE,
   input wire MATH_TRAP_PULSE,
   input wire ALT_VECTOR,
   input wire NEST_BLOCK,
   input wire [15:0] REQ_FLAGS0
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   // Shadow of the three overflow trap enables, taken from bus writes
   logic [2:0] ten;
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         ten <= 3'h0;
      end else if (WR && ADDR == `OFS_TRAP_STATUS_CONTROL) begin
         ten <= WDATA[10:8];
      end
   end
   // Overflows an enable lets through; a bare overflow is no cause
   wire ovf_trap = (ACC_A_OVF && ten[2]) || (ACC_B_OVF && ten[1]) ||
      ((ACC_A_COVF || ACC_B_COVF) && ten[0]);
   wire any_trap = ovf_trap | BAD_SHIFT | DIV_ZERO | ADDR_ERR |
      STACK_ERR | OSC_FAIL;
   wire [15:0] fmask = `MASK_REQ_FLAGS_BANK_ZERO;
   //////////////////////////////////////////////////////////////////////////
   // Vector select written, then read back at once
   sequence s_alt_set;
      WR && ADDR == `OFS_VECTOR_EDGE_CONTROL && WDATA[15];
   endsequence
   sequence s_alt_read;
      RD && ADDR == `OFS_VECTOR_EDGE_CONTROL;
   endsequence
   a_alt_readback: assert property (
      s_alt_set ##1 s_alt_read |=> RDATA[15])
      else $error("vector select not read back");
   a_alt_follows: assert property (
      WR && ADDR == `OFS_VECTOR_EDGE_CONTROL |=>
      ALT_VECTOR == $past(WDATA[15]))
      else $error("vector select output wrong");
   a_shift_trap: assert property (
      BAD_SHIFT |=> MATH_TRAP_PULSE && TRAP_PULSE)
      else $error("bad shift gave no math trap");
   a_div_trap: assert property (
      DIV_ZERO |=> MATH_TRAP_PULSE && TRAP_PULSE)
      else $error("divide by zero gave no math trap");
   a_math_is_trap: assert property (
      MATH_TRAP_PULSE |-> TRAP_PULSE)
      else $error("math trap without trap pulse");
   a_plain_trap: assert property (
      ADDR_ERR || STACK_ERR || OSC_FAIL |=> TRAP_PULSE)
      else $error("error event gave no trap");
   a_ovf_trap: assert property (
      ovf_trap |=> MATH_TRAP_PULSE && TRAP_PULSE)
      else $error("enabled overflow gave no math trap");
   a_trap_cause: assert property (
      TRAP_PULSE |-> $past(any_trap))
      else $error("trap pulse without enabled cause");
   a_unmapped_zero: assert property (
      RD && ADDR[2] |=> RDATA == 16'h0000)
      else $error("unmapped index read nonzero");
   a_flag_sticks: assert property (
      |(BANK0_EVT & fmask) |=> &(REQ_FLAGS0 | ~($past(BANK0_EVT) & fmask)))
      else $error("event did not set its flag");
   a_flag_clear_sw: assert property (
      |($past(REQ_FLAGS0) & ~REQ_FLAGS0) |->
      $past(WR) && $past(ADDR) == `OFS_REQ_FLAGS_BANK_ZERO)
      else $error("flag dropped without software write");
   a_nest_open: assert property (
      WR && ADDR == `OFS_TRAP_STATUS_CONTROL && !WDATA[15] |=> !NEST_BLOCK)
      else $error("nesting blocked while enabled");
endmodule // trap_flag_checker
bind trap_and_interrupt_flag_control trap_flag_checker u_check (
   .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
   .RD(RD), .RDATA(RDATA), .ACC_A_OVF(ACC_A_OVF), .ACC_B_OVF(ACC_B_OVF),
   .ACC_A_COVF(ACC_A_COVF), .ACC_B_COVF(ACC_B_COVF),
   .BAD_SHIFT(BAD_SHIFT), .DIV_ZERO(DIV_ZERO), .ADDR_ERR(ADDR_ERR),
   .STACK_ERR(STACK_ERR), .OSC_FAIL(OSC_FAIL), .BANK0_EVT(BANK0_EVT),
   .TRAP_PULSE(TRAP_PULSE), .MATH_TRAP_PULSE(MATH_TRAP_PULSE),
   .ALT_VECTOR(ALT_VECTOR), .NEST_BLOCK(NEST_BLOCK),
   .REQ_FLAGS0(REQ_FLAGS0)
);
